// ### shared/mcal_defs.vh
`ifndef MCAL_DEFS_VH
`define MCAL_DEFS_VH

// clock rate and timing
`define MCAL_CLK_HZ 25000000
`define MCAL_LONG_MS 2000
`define MCAL_DEB_MS 10
`define MCAL_BLINK_MS 250
// long press is a least time: kHz division truncates, cycles rounded down
`define MCAL_LONG_CYC ((`MCAL_CLK_HZ / 1000) * `MCAL_LONG_MS)
`define MCAL_DEB_CYC ((`MCAL_CLK_HZ / 1000) * `MCAL_DEB_MS)
`define MCAL_BLINK_CYC ((`MCAL_CLK_HZ / 1000) * `MCAL_BLINK_MS)

// lamp blink counts
`define MCAL_BLINKS_GAIN 4'h2
`define MCAL_BLINKS_OFFS 4'h4
`define MCAL_BLINKS_SAVE 4'h1
`define MCAL_BLINKS_AUTO 4'h6

// parameter widths, steps and defaults
`define MCAL_PW 16
`define MCAL_STEP_COARSE 16'h0100
`define MCAL_STEP_FINE 16'h0001
`define MCAL_GAIN_DEF 16'h8000
`define MCAL_OFFS_DEF 16'h8000

`endif

// ### rtl/mcal_fsm.v
`timescale 1ns/1ps
`default_nettype none
`include "mcal_defs.vh"

// How it works
// [RULE_01] In normal mode a long mode press enters gain adjust and blinks the lamp twice.
// [RULE_02] In gain adjust a short zero press steps gain coarsely, a short mode press finely.
// [RULE_03] In gain adjust a long mode press enters offset adjust and blinks four times.
// [RULE_04] In offset adjust short zero and mode presses step the offset coarse and fine.
// [RULE_05] In offset adjust a long mode press stores both values, blinks once, returns to normal.
// [RULE_06] A power-up reset drops an unsaved session and reloads the stored values.
// [RULE_07] Stored values survive power loss and are reloaded at power-up.
// [RULE_08] The valid flag is high only outside an adjust session and its blinks.
// [RULE_09] In normal mode a long zero press aligns the offset, stores it, blinks six times.
// [RULE_10] Both buttons are debounced, and a press is long if held the long time, else short.
module mcal_fsm #(
	parameter LONG_CYC = `MCAL_LONG_CYC,
	parameter DEB_CYC = `MCAL_DEB_CYC,
	parameter BLINK_CYC = `MCAL_BLINK_CYC
) (
	input wire clk_sys_in,
	input wire sys_rst_in,
	input wire zero_coarse_button_in,
	input wire mode_fine_button_in,
	input wire [`MCAL_PW-1:0] stored_gain_in,
	input wire [`MCAL_PW-1:0] stored_offset_in,
	input wire [`MCAL_PW-1:0] auto_offset_in,
	output reg [`MCAL_PW-1:0] gain_out,
	output reg [`MCAL_PW-1:0] offset_out,
	output reg store_req_out,
	output reg [`MCAL_PW-1:0] store_gain_out,
	output reg [`MCAL_PW-1:0] store_offset_out,
	output reg mode_indicator_lamp_out,
	output reg meas_valid_out,
	output wire [1:0] adjust_mode_out
);
	localparam S_LOAD = 6'h01;
	localparam S_NORM = 6'h02;
	localparam S_GAIN = 6'h04;
	localparam S_OFFS = 6'h08;
	localparam S_SAVE = 6'h10;
	localparam S_BLNK = 6'h20;

	reg [5:0] state;
	reg [5:0] after_blink;
	reg [3:0] blinks_left;
	// 32-bit counters cover the full-rate long press of fifty million cycles
	reg [31:0] blink_cnt;
	wire [1:0] btn_raw;
	wire [1:0] short_p;
	wire [1:0] long_p;

	assign btn_raw = {mode_fine_button_in, zero_coarse_button_in};

	// adjust steps only count up and wrap at the top; an operator who
	// overshoots goes round once more, the price of having two buttons only
	function [`MCAL_PW-1:0] step_val;
		input [`MCAL_PW-1:0] cur;
		input coarse;
		begin
			if (coarse) begin
				step_val = cur + `MCAL_STEP_COARSE;
			end else begin
				step_val = cur + `MCAL_STEP_FINE;
			end
		end
	endfunction

	// index 0 is the zero/coarse button, index 1 the mode/fine button
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_btn
			reg s1, s2, deb, long_done;
			reg [31:0] deb_cnt, hold_cnt;
			reg sp, lp;
			always @(posedge clk_sys_in) begin
				s1 <= btn_raw[gi];
				s2 <= s1;
				sp <= 1'b0;
				lp <= 1'b0;
				if (sys_rst_in) begin
					deb <= 1'b0;
					deb_cnt <= 32'h0;
					hold_cnt <= 32'h0;
					long_done <= 1'b0;
				end else begin
					// level must be steady for the debounce time before it is taken
					if (s2 == deb) begin
						deb_cnt <= 32'h0;
					end else if (deb_cnt >= DEB_CYC - 1) begin
						deb_cnt <= 32'h0;
						deb <= s2; // RULE_10
					end else begin
						deb_cnt <= deb_cnt + 32'h1;
					end
					// hold_cnt stops at the long mark so a very long press cannot wrap it
					if (deb) begin
						if (!long_done && hold_cnt >= LONG_CYC - 1) begin
							// long acts while still held, so the lamp answers at once
							lp <= 1'b1; // RULE_10
							long_done <= 1'b1;
						end else if (!long_done) begin
							hold_cnt <= hold_cnt + 32'h1;
						end
					end else begin
						if (hold_cnt != 32'h0 && !long_done) begin
							sp <= 1'b1; // RULE_10
						end
						hold_cnt <= 32'h0;
						long_done <= 1'b0;
					end
				end
			end
			assign short_p[gi] = sp;
			assign long_p[gi] = lp;
		end
	endgenerate

	// taken straight from the one-hot state, so two modes never show at once
	assign adjust_mode_out = {state == S_OFFS, state == S_GAIN};

	always @(posedge clk_sys_in) begin
		store_req_out <= 1'b0;
		if (sys_rst_in) begin
			// power-up: the working copy parks at defaults until the stored copy is read
			state <= S_LOAD; // RULE_06
			after_blink <= S_NORM;
			blinks_left <= 4'h0;
			blink_cnt <= 32'h0;
			mode_indicator_lamp_out <= 1'b0;
			meas_valid_out <= 1'b0;
			gain_out <= `MCAL_GAIN_DEF;
			offset_out <= `MCAL_OFFS_DEF;
			store_gain_out <= `MCAL_GAIN_DEF;
			store_offset_out <= `MCAL_OFFS_DEF;
		end else begin
			case (state)
				S_LOAD: begin
					// unsaved edits are gone; stored copy is the truth after power-up
					gain_out <= stored_gain_in; // RULE_06
					offset_out <= stored_offset_in; // RULE_07
					meas_valid_out <= 1'b1; // RULE_08
					state <= S_NORM;
				end
				S_NORM: begin
					// short presses mean nothing here; the mode long press wins if both are held
					if (long_p[1]) begin
						meas_valid_out <= 1'b0; // RULE_08
						blinks_left <= `MCAL_BLINKS_GAIN; // RULE_01
						after_blink <= S_GAIN;
						blink_cnt <= 32'h0;
						state <= S_BLNK;
					end else if (long_p[0]) begin
						// auto alignment keeps the working gain and stores it unchanged
						meas_valid_out <= 1'b0;
						offset_out <= auto_offset_in; // RULE_09
						store_gain_out <= gain_out;
						store_offset_out <= auto_offset_in;
						store_req_out <= 1'b1; // RULE_09
						blinks_left <= `MCAL_BLINKS_AUTO; // RULE_09
						after_blink <= S_NORM;
						blink_cnt <= 32'h0;
						state <= S_BLNK;
					end
				end
				S_GAIN: begin
					if (long_p[1]) begin
						blinks_left <= `MCAL_BLINKS_OFFS; // RULE_03
						after_blink <= S_OFFS;
						blink_cnt <= 32'h0;
						state <= S_BLNK;
					end else if (short_p[0]) begin
						gain_out <= step_val(gain_out, 1'b1); // RULE_02
					end else if (short_p[1]) begin
						gain_out <= step_val(gain_out, 1'b0); // RULE_02
					end
				end
				S_OFFS: begin
					if (long_p[1]) begin
						state <= S_SAVE;
					end else if (short_p[0]) begin
						offset_out <= step_val(offset_out, 1'b1); // RULE_04
					end else if (short_p[1]) begin
						offset_out <= step_val(offset_out, 1'b0); // RULE_04
					end
				end
				S_SAVE: begin
					// data and request leave together so the store never sees half a pair
					store_gain_out <= gain_out;
					store_offset_out <= offset_out;
					store_req_out <= 1'b1; // RULE_05
					blinks_left <= `MCAL_BLINKS_SAVE; // RULE_05
					after_blink <= S_NORM;
					blink_cnt <= 32'h0;
					state <= S_BLNK;
				end
				S_BLNK: begin
					// presses seen while blinking are dropped, so a held button cannot run ahead
					// each blink is one on phase and one off phase; the next mode is entered
					// as the last blink goes dark, so that last off phase is not waited out
					if (blink_cnt >= BLINK_CYC - 1) begin
						blink_cnt <= 32'h0;
						if (mode_indicator_lamp_out) begin
							mode_indicator_lamp_out <= 1'b0;
							blinks_left <= blinks_left - 4'h1;
							if (blinks_left == 4'h1) begin
								state <= after_blink;
								meas_valid_out <= (after_blink == S_NORM); // RULE_08
							end
						end else begin
							mode_indicator_lamp_out <= 1'b1;
						end
					end else begin
						blink_cnt <= blink_cnt + 32'h1;
					end
				end
				default: begin
					state <= S_LOAD;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// ### tb/mcal_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcal_defs.vh"
module mcal_asserts (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [`MCAL_PW-1:0] gain_out,
	input wire logic store_req_out,
	input wire logic [`MCAL_PW-1:0] store_gain_out,
	input wire logic mode_indicator_lamp_out,
	input wire logic meas_valid_out,
	input wire logic [1:0] adjust_mode_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	property p_pul; store_req_out |=> !store_req_out; endproperty
	a_pul: assert property (p_pul) else $error("store pulse long");
	property p_dat; store_req_out |=> $stable(store_gain_out)[*4]; endproperty
	a_dat: assert property (p_dat) else $error("store data moved");
	property p_ofs; $rose(adjust_mode_out[1]) |->
		$past(mode_indicator_lamp_out) && !meas_valid_out; endproperty
	a_ofs: assert property (p_ofs) else $error("offset entry");
	property p_adj; adjust_mode_out != 2'b00 |-> !meas_valid_out; endproperty
	a_adj: assert property (p_adj) else $error("valid in session");
	property p_lmp; mode_indicator_lamp_out |-> !meas_valid_out; endproperty
	a_lmp: assert property (p_lmp) else $error("valid in blink");
	property p_gan; $changed(gain_out) |-> $past(sys_rst_in, 2) || $past(adjust_mode_out[0]);
	endproperty
	a_gan: assert property (p_gan) else $error("gain moved");
	property p_on; $rose(mode_indicator_lamp_out) |-> mode_indicator_lamp_out[*8]
		##1 !mode_indicator_lamp_out; endproperty
	a_on: assert property (p_on) else $error("lamp on time");
	property p_off; $fell(mode_indicator_lamp_out) |-> !mode_indicator_lamp_out[*8]; endproperty
	a_off: assert property (p_off) else $error("lamp off time");
endmodule
bind mcal_fsm mcal_asserts u_chk (.clk_sys_in, .sys_rst_in, .gain_out, .store_req_out,
	.store_gain_out, .mode_indicator_lamp_out, .meas_valid_out, .adjust_mode_out);
`default_nettype wire

// ### tb/mcal_btn.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcal_defs.vh"
module mcal_btn (
	input wire logic clk_in,
	input wire logic req_in,
	input wire logic [`MCAL_PW-1:0] gain_in,
	input wire logic [`MCAL_PW-1:0] offs_in,
	output var logic zero_out = 1'b0,
	output var logic mode_out = 1'b0,
	output var logic [`MCAL_PW-1:0] gain_out = 16'h1200,
	output var logic [`MCAL_PW-1:0] offs_out = 16'h3400
);
	// the store lives outside the device, so its resets never touch it
	always @(posedge clk_in) begin
		if (req_in) begin
			gain_out <= gain_in;
			offs_out <= offs_in;
		end
	end
	task automatic hold(input bit z, input int n);
		if (z) zero_out = 1'b1;
		else mode_out = 1'b1;
		repeat (n) @(posedge clk_in);
		#1 zero_out = 1'b0;
		mode_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_manual_calibration_mode_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcal_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_manual_calibration_mode_fsm;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic zb, mb, req, lamp, valid;
	logic [`MCAL_PW-1:0] sg, so, g, o, wg, wo;
	logic [1:0] md;
	logic [`MCAL_PW-1:0] ao = 16'h0;
	int err_total = 0;
	int checks = 0;
	int rises = 0;
	always #20 clk = ~clk;
	always @(posedge lamp) rises++;
	mcal_fsm #(.LONG_CYC(40), .DEB_CYC(4), .BLINK_CYC(8)) DUT (.clk_sys_in(clk),
		.sys_rst_in(rst), .zero_coarse_button_in(zb), .mode_fine_button_in(mb),
		.stored_gain_in(sg), .stored_offset_in(so), .auto_offset_in(ao),
		.gain_out(g), .offset_out(o), .store_req_out(req), .store_gain_out(wg),
		.store_offset_out(wo), .mode_indicator_lamp_out(lamp), .meas_valid_out(valid),
		.adjust_mode_out(md));
	mcal_btn u_btn (.clk_in(clk), .req_in(req), .gain_in(wg), .offs_in(wo),
		.zero_out(zb), .mode_out(mb), .gain_out(sg), .offs_out(so));
	task conclude;
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task reboot;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
	endtask
	// a press of n cycles, then room for b blinks to finish
	task go(input bit z, input int n, input int b);
		rises = 0;
		u_btn.hold(z, n);
		repeat (16 * b + 24) @(posedge clk);
		#1;
		`CHK("blinks", b, rises)
	endtask
	task t_gain;
		go(0, 50, 2);
		`CHK("mode", 2'b01, md)
		go(1, 12, 0);
		go(0, 12, 0);
		`CHK("gain", 16'h1301, g)
	endtask
	task t_abort;
		go(0, 50, 4);
		`CHK("mode", 2'b10, md)
		go(1, 12, 0);
		`CHK("offs", 16'h3500, o)
		reboot();
		`CHK("gain", 16'h1200, g)
		`CHK("offs", 16'h3400, o)
	endtask
	task t_save;
		go(0, 50, 2);
		go(1, 12, 0);
		go(0, 50, 4);
		go(0, 12, 0);
		go(0, 50, 1);
		`CHK("stored", 32'h13003401, {sg, so})
		`CHK("valid", 1'b1, valid)
		reboot();
		`CHK("reload", 32'h13003401, {g, o})
	endtask
	task t_auto;
		go(1, 12, 0);
		`CHK("idle", 32'h13003401, {g, o})
		ao = 16'h7f00;
		go(1, 50, 6);
		`CHK("auto", 32'h7f007f00, {o, so})
		`CHK("autog", 16'h1300, sg)
		`CHK("valid", 1'b1, valid)
	endtask
	initial begin
		reboot();
		`CHK("valid", 1'b1, valid)
		t_gain();
		t_abort();
		t_save();
		t_auto();
		conclude();
	end
	initial begin
		#400000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
